// ==== include/fel_defs.svh ====
// register map, field positions and reset values of the fault unit
// assumes a 32-bit apb slave with byte addresses in paddr
`ifndef FEL_DEFS_SVH
`define FEL_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FEL_AW        8
`define FEL_OFF_HFS   8'h00
`define FEL_OFF_MMS   8'h04
`define FEL_OFF_BFS   8'h08
`define FEL_OFF_UFS   8'h0c
`define FEL_OFF_MMA   8'h10
`define FEL_OFF_BFA   8'h14
`define FEL_OFF_PRI   8'h18
`define FEL_OFF_HCTL  8'h1c
`define FEL_OFF_LOCK  8'h20

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define FEL_HF_VEC_RD 1
`define FEL_HF_ESCALATION_FLAG 30
`define FEL_MM_IACC   0
`define FEL_MM_DACC   1
`define FEL_MM_UNSTK  3
`define FEL_MM_STK    4
`define FEL_MM_AVLD   7
`define FEL_BF_FETCH  0
`define FEL_BF_EXACT  1
`define FEL_BF_INEX   2
`define FEL_BF_UNSTK  3
`define FEL_BF_STK    4
`define FEL_BF_AVLD   7
`define FEL_UF_UNDEFINED_INSTR_FLAG  0
`define FEL_UF_INVST  1
`define FEL_UF_INVRET 2
`define FEL_UF_COPROC 3
`define FEL_UF_UNALN  8
`define FEL_UF_DIVZ   9

// ----------------------------------------------------------------------
// priority and handler control fields, reset values
// ----------------------------------------------------------------------
`define FEL_PRI_W     3
`define FEL_PRI_STEP  8
`define FEL_PRI_MASK  32'h0007_0707
`define FEL_HCTL_MASK 32'h0000_0007
`define FEL_RST_ZERO  32'h0000_0000
`define FEL_PRI_IDLE  3'h7
`define FEL_PRI_TOP   3'h0

`endif

// ==== include/fel_pkg.sv ====
// types shared by the fault escalation and lockup unit
// assumes fault reports come from logic on the processor clock
package fel_pkg;

  // ----------------------------------------------------------------------
  // active exception seen by the unit
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FEL_EXC_THREAD = 3'b000,
    FEL_EXC_NMI    = 3'b001,
    FEL_EXC_HARD   = 3'b010,
    FEL_EXC_MEMM   = 3'b011,
    FEL_EXC_BUSF   = 3'b100,
    FEL_EXC_USAGE  = 3'b101,
    FEL_EXC_OTHER  = 3'b110
  } fel_exc_t;

  typedef enum logic [1:0] {
    FEL_LK_RUN = 2'b00,
    FEL_LK_HF  = 2'b01,
    FEL_LK_NMI = 2'b10
  } fel_lk_t;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        vec_bus_err;
    logic        ifetch_prot_viol;
    logic        ifetch_never_exec;
    logic        data_prot_viol;
    logic        stack_prot_viol;
    logic        unstack_prot_viol;
    logic        stack_bus_err;
    logic        unstack_bus_err;
    logic        ifetch_bus_err;
    logic        data_bus_err;
    logic        data_err_exact;
    logic        coproc;
    logic        undefined_instr_flag_instr;
    logic        nonnative_set;
    logic        cont_state_bad;
    logic        bad_return;
    logic        unaligned;
    logic        div_zero;
    logic [31:0] addr;
  } fel_report_t;

  typedef struct packed {
    fel_exc_t   active;
    logic [2:0] act_pri;
    logic       bf_entry_stack;
  } fel_ctx_t;

  typedef struct packed {
    logic hard;
    logic memm;
    logic busf;
    logic usage;
  } fel_req_t;

endpackage

// ==== design/fel_fault_class.sv ====
// fault classifier: turns raw error reports into cause flag set vectors
// assumes reports are single-cycle pulses on the processor clock
`timescale 1ns/1ps
`default_nettype none
`include "fel_defs.svh"

module fel_fault_class
  import fel_pkg::*;
(
  input  wire fel_report_t rpt,
  output logic [31:0]      mm_set,
  output logic [31:0]      bf_set,
  output logic [31:0]      uf_set
);

  // ----------------------------------------------------------------------
  // cause decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    mm_set = `FEL_RST_ZERO;
    bf_set = `FEL_RST_ZERO;
    uf_set = `FEL_RST_ZERO;
    // never-execute fetch faults with or without the protection unit
    mm_set[`FEL_MM_IACC]  = rpt.ifetch_prot_viol; // RQ3
    mm_set[`FEL_MM_IACC]  = mm_set[`FEL_MM_IACC] | rpt.ifetch_never_exec; // RQ4
    mm_set[`FEL_MM_DACC]  = rpt.data_prot_viol; // RQ5
    mm_set[`FEL_MM_STK]   = rpt.stack_prot_viol; // RQ6
    mm_set[`FEL_MM_UNSTK] = rpt.unstack_prot_viol; // RQ6
    mm_set[`FEL_MM_AVLD]  = rpt.ifetch_prot_viol | rpt.ifetch_never_exec |
                            rpt.data_prot_viol; // RQ19
    bf_set[`FEL_BF_STK]   = rpt.stack_bus_err; // RQ7
    bf_set[`FEL_BF_UNSTK] = rpt.unstack_bus_err; // RQ7
    bf_set[`FEL_BF_FETCH] = rpt.ifetch_bus_err; // RQ8
    bf_set[`FEL_BF_EXACT] = rpt.data_bus_err & rpt.data_err_exact; // RQ9
    bf_set[`FEL_BF_INEX]  = rpt.data_bus_err & ~rpt.data_err_exact; // RQ9
    // an inexact error carries no trustworthy address
    bf_set[`FEL_BF_AVLD]  = rpt.ifetch_bus_err |
                            (rpt.data_bus_err & rpt.data_err_exact); // RQ19
    uf_set[`FEL_UF_COPROC] = rpt.coproc; // RQ10
    uf_set[`FEL_UF_UNDEFINED_INSTR_FLAG]  = rpt.undefined_instr_flag_instr; // RQ10
    uf_set[`FEL_UF_INVST]  = rpt.nonnative_set | rpt.cont_state_bad; // RQ11
    uf_set[`FEL_UF_INVRET] = rpt.bad_return; // RQ10
    uf_set[`FEL_UF_UNALN]  = rpt.unaligned; // RQ10
    uf_set[`FEL_UF_DIVZ]   = rpt.div_zero; // RQ10
  end

endmodule
`default_nettype wire

// ==== design/fel_top.sv ====
// fault escalation and lockup unit with its apb register file
// assumes reports and context come from logic on mclk; apb on mclk
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fel_defs.svh"

// Summary of operation
// RQ1: vector read bus error sets vector flag, hard
// RQ2: any escalation sets the escalation flag
// RQ3: fetch protection violation raises instruction access flag
// RQ4: never-execute fetch faults even without protection
// RQ5: data protection violation raises data access flag
// RQ6: stacking and unstacking violations have own flags
// RQ7: stacking and unstacking bus errors have own flags
// RQ8: prefetch bus error sets instruction bus flag
// RQ9: data bus error sets exact or inexact flag
// RQ10: six usage causes each have own flag
// RQ11: invalid state covers foreign set, bad continuation
// RQ12: configurable priority and handler enable per class
// RQ13: fault in own class handler escalates
// RQ14: fault not above serviced fault escalates
// RQ15: fault not above active exception escalates
// RQ16: fault with disabled handler escalates
// RQ17: bus error stacking bus handler never escalates
// RQ18: hard fault preempted only by reset, nmi
// RQ19: capture faulting address for bus, memory faults
// RQ20: hard fault in nmi or hard handler locks
// RQ21: lockup left on reset, nmi or halt
// RQ22: lockup from nmi handler ignores later nmi
// RQ23: equal priority never preempts, only pends; here an equal-level fault escalates to hard
// RQ24: cause flags stay set until software clears
module fel_top
  import fel_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [`FEL_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire fel_report_t       rpt,
  input  wire fel_ctx_t          ctx,
  input  wire logic              nmi_req,
  input  wire logic              dbg_halt,
  output fel_req_t               fault_req,
  output logic                   lockup
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [31:0] hfs_r, hfs_nxt, mms_r, mms_nxt, bfs_r, bfs_nxt;
  logic [31:0] ufs_r, ufs_nxt, mma_r, mma_nxt, bfa_r, bfa_nxt;
  logic [31:0] pri_r, pri_nxt, hctl_r, hctl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  fel_req_t    req_r, req_nxt;
  fel_lk_t     lk_r, lk_nxt;
  logic        lockup_r, lockup_nxt;

  logic [31:0] mm_set, bf_set, uf_set, hfs_set;
  logic [2:0]  cls_any, esc;
  logic [2:0]  act_pri;
  logic        in_hdl, mapped, setup, wr_acc;
  logic        hard_any, crit_hdl, lock_hit, exempt;

  fel_fault_class u_class
  (
    .rpt    (rpt),
    .mm_set (mm_set),
    .bf_set (bf_set),
    .uf_set (uf_set)
  );

  // ----------------------------------------------------------------------
  // escalation
  // ----------------------------------------------------------------------
  assign cls_any[0] = |mm_set;
  assign cls_any[1] = |bf_set;
  assign cls_any[2] = |uf_set;
  assign crit_hdl   = (ctx.active == FEL_EXC_NMI) ||
                      (ctx.active == FEL_EXC_HARD);
  // stacking for bus fault entry keeps the bus fault handler
  assign exempt = rpt.stack_bus_err & ctx.bf_entry_stack; // RQ17

  // current priority level, taking fault handler levels from pri_r
  always_comb
  begin
    in_hdl  = 1'b1;
    act_pri = ctx.act_pri;
    unique case (ctx.active)
      FEL_EXC_THREAD:
      begin
        in_hdl  = 1'b0;
        act_pri = `FEL_PRI_IDLE;
      end
      FEL_EXC_NMI:   act_pri = `FEL_PRI_TOP;
      FEL_EXC_HARD:  act_pri = `FEL_PRI_TOP;
      FEL_EXC_MEMM:  act_pri = pri_r[0 +: `FEL_PRI_W]; // RQ13
      FEL_EXC_BUSF:  act_pri = pri_r[`FEL_PRI_STEP +: `FEL_PRI_W]; // RQ13
      FEL_EXC_USAGE: act_pri = pri_r[2*`FEL_PRI_STEP +: `FEL_PRI_W]; // RQ13
      FEL_EXC_OTHER: act_pri = ctx.act_pri; // RQ15
      default:       act_pri = ctx.act_pri;
    endcase
  end

  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1)
    begin : g_cls
      logic [2:0] cpri;
      logic       slow;
      assign cpri = pri_r[c*`FEL_PRI_STEP +: `FEL_PRI_W]; // RQ12
      // equal level cannot preempt, so it escalates instead
      assign slow = in_hdl & (cpri >= act_pri); // RQ14 RQ15 RQ23
      assign esc[c] = cls_any[c] & (~hctl_r[c] | slow) & // RQ16
                      ~((c == 1) & exempt); // RQ17
    end
  endgenerate

  assign hard_any = rpt.vec_bus_err | (|esc); // RQ1
  // hard fault cannot preempt nmi or another hard fault
  assign lock_hit = hard_any & crit_hdl; // RQ18 RQ20

  always_comb
  begin
    hfs_set = `FEL_RST_ZERO;
    hfs_set[`FEL_HF_VEC_RD] = rpt.vec_bus_err; // RQ1
    hfs_set[`FEL_HF_ESCALATION_FLAG] = |esc; // RQ2
  end

  // ----------------------------------------------------------------------
  // requests and lockup
  // ----------------------------------------------------------------------
  always_comb
  begin
    req_nxt = '0;
    lk_nxt  = lk_r;
    if (lk_r == FEL_LK_RUN)
    begin
      req_nxt.hard  = hard_any & ~crit_hdl; // RQ18
      req_nxt.memm  = cls_any[0] & ~esc[0];
      req_nxt.busf  = cls_any[1] & ~esc[1]; // RQ17
      req_nxt.usage = cls_any[2] & ~esc[2];
    end
    unique case (lk_r)
      FEL_LK_RUN:
      begin
        if (lock_hit)
          lk_nxt = (ctx.active == FEL_EXC_NMI) ? FEL_LK_NMI
                                                : FEL_LK_HF; // RQ20
      end
      FEL_LK_HF:
      begin
        if (dbg_halt || nmi_req)
          lk_nxt = FEL_LK_RUN; // RQ21
      end
      FEL_LK_NMI:
      begin
        if (dbg_halt)
          lk_nxt = FEL_LK_RUN; // RQ21 RQ22
      end
      default: lk_nxt = FEL_LK_RUN;
    endcase
    lockup_nxt = (lk_nxt != FEL_LK_RUN);
  end

  // ----------------------------------------------------------------------
  // apb slave and registers
  // ----------------------------------------------------------------------
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready_r & pwrite & ~pslverr_r;

  always_comb
  begin
    unique case (paddr)
      `FEL_OFF_HFS, `FEL_OFF_MMS, `FEL_OFF_BFS, `FEL_OFF_UFS,
      `FEL_OFF_MMA, `FEL_OFF_BFA, `FEL_OFF_PRI, `FEL_OFF_HCTL,
      `FEL_OFF_LOCK: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    hfs_nxt  = hfs_r;
    mms_nxt  = mms_r;
    bfs_nxt  = bfs_r;
    ufs_nxt  = ufs_r;
    mma_nxt  = mma_r;
    bfa_nxt  = bfa_r;
    pri_nxt  = pri_r;
    hctl_nxt = hctl_r;
    pready_nxt  = setup;
    pslverr_nxt = setup & ~mapped;
    prdata_nxt  = prdata_r;
    if (wr_acc)
    begin
      unique case (paddr)
        `FEL_OFF_HFS:  hfs_nxt  = hfs_r & ~pwdata;
        `FEL_OFF_MMS:  mms_nxt  = mms_r & ~pwdata;
        `FEL_OFF_BFS:  bfs_nxt  = bfs_r & ~pwdata;
        `FEL_OFF_UFS:  ufs_nxt  = ufs_r & ~pwdata;
        `FEL_OFF_PRI:  pri_nxt  = pwdata & `FEL_PRI_MASK; // RQ12
        `FEL_OFF_HCTL: hctl_nxt = pwdata & `FEL_HCTL_MASK; // RQ12
        default:       hctl_nxt = hctl_r;
      endcase
    end
    // a new cause in the clearing cycle survives the clear
    hfs_nxt = hfs_nxt | hfs_set; // RQ24
    mms_nxt = mms_nxt | mm_set; // RQ24
    bfs_nxt = bfs_nxt | bf_set; // RQ24
    ufs_nxt = ufs_nxt | uf_set; // RQ24
    if (mm_set[`FEL_MM_AVLD])
      mma_nxt = rpt.addr; // RQ19
    if (bf_set[`FEL_BF_AVLD])
      bfa_nxt = rpt.addr; // RQ19
    if (setup)
    begin
      unique case (paddr)
        `FEL_OFF_HFS:  prdata_nxt = hfs_r;
        `FEL_OFF_MMS:  prdata_nxt = mms_r;
        `FEL_OFF_BFS:  prdata_nxt = bfs_r;
        `FEL_OFF_UFS:  prdata_nxt = ufs_r;
        `FEL_OFF_MMA:  prdata_nxt = mma_r;
        `FEL_OFF_BFA:  prdata_nxt = bfa_r;
        `FEL_OFF_PRI:  prdata_nxt = pri_r;
        `FEL_OFF_HCTL: prdata_nxt = hctl_r;
        `FEL_OFF_LOCK: prdata_nxt = {30'h0000_0000, lk_r};
        default:       prdata_nxt = `FEL_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      hfs_r     <= `FEL_RST_ZERO;
      mms_r     <= `FEL_RST_ZERO;
      bfs_r     <= `FEL_RST_ZERO;
      ufs_r     <= `FEL_RST_ZERO;
      mma_r     <= `FEL_RST_ZERO;
      bfa_r     <= `FEL_RST_ZERO;
      pri_r     <= `FEL_RST_ZERO;
      hctl_r    <= `FEL_RST_ZERO;
      prdata_r  <= `FEL_RST_ZERO;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      req_r     <= '0;
      lk_r      <= FEL_LK_RUN; // RQ21
      lockup_r  <= 1'b0;
    end
    else
    begin
      hfs_r     <= hfs_nxt;
      mms_r     <= mms_nxt;
      bfs_r     <= bfs_nxt;
      ufs_r     <= ufs_nxt;
      mma_r     <= mma_nxt;
      bfa_r     <= bfa_nxt;
      pri_r     <= pri_nxt;
      hctl_r    <= hctl_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      req_r     <= req_nxt;
      lk_r      <= lk_nxt;
      lockup_r  <= lockup_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign fault_req = req_r;
  assign lockup    = lockup_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_vector_flag: assert property (@(posedge mclk) disable iff (rst) // RQ1
    rpt.vec_bus_err |=> hfs_r[`FEL_HF_VEC_RD])
    else $error("vector read error flag not set");

  chk_escalation_flag_flag: assert property (@(posedge mclk) disable iff (rst) // RQ2
    (|esc) |=> hfs_r[`FEL_HF_ESCALATION_FLAG] ##0 $past(lk_r) != FEL_LK_RUN
      || fault_req.hard || lockup)
    else $error("escalation left no trace");

  chk_disabled_esc: assert property (@(posedge mclk) disable iff (rst) // RQ16
    (rpt.ifetch_never_exec && !hctl_r[0] && lk_r == FEL_LK_RUN &&
     !crit_hdl) |=> (fault_req.hard && !fault_req.memm))
    else $error("disabled handler fault not escalated");

  chk_own_class: assert property (@(posedge mclk) disable iff (rst) // RQ13
    (rpt.div_zero && hctl_r[2] && ctx.active == FEL_EXC_USAGE &&
     lk_r == FEL_LK_RUN) |=> (fault_req.hard && !fault_req.usage))
    else $error("same class fault not escalated");

  chk_bf_exempt: assert property (@(posedge mclk) disable iff (rst) // RQ17
    (exempt && hctl_r[1] && !crit_hdl && lk_r == FEL_LK_RUN)
      |=> fault_req.busf)
    else $error("bus fault on bus entry stacking escalated");

  chk_lock_entry: assert property (@(posedge mclk) disable iff (rst) // RQ20
    (lock_hit && lk_r == FEL_LK_RUN) |=> (lockup && !fault_req.hard))
    else $error("lockup not entered");

  chk_nmi_hold: assert property (@(posedge mclk) disable iff (rst) // RQ22
    (lk_r == FEL_LK_NMI && nmi_req && !dbg_halt) |=> lockup)
    else $error("nmi released lockup entered from nmi");

  chk_lock_exit: assert property (@(posedge mclk) disable iff (rst) // RQ21
    (lockup && (dbg_halt || (nmi_req && lk_r == FEL_LK_HF)))
      |=> !lockup)
    else $error("lockup not left");

  chk_sticky_flag: assert property (@(posedge mclk) disable iff (rst) // RQ24
    (mms_r[`FEL_MM_IACC] && !(wr_acc && paddr == `FEL_OFF_MMS))
      |=> mms_r[`FEL_MM_IACC])
    else $error("cause flag lost without clear");

  chk_addr_capture: assert property (@(posedge mclk) disable iff (rst) // RQ19
    rpt.data_prot_viol |=> mma_r == $past(rpt.addr))
    else $error("fault address not captured");

  chk_apb_ready: assert property (@(posedge mclk) disable iff (rst)
    setup |=> (pready && (pslverr == !$past(mapped))))
    else $error("apb access not answered");

endmodule
`default_nettype wire

// ==== verif/fel_src_model.sv ====
// report source model: the fetch, data, stacking and decode paths
// assumes one request on go for one cycle; pulses the report a cycle later
`timescale 1ns/1ps
`default_nettype none

module fel_src_model
  import fel_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire fel_report_t want,
  output fel_report_t      rpt
);
  logic [31:0] last_r;

  // ----------------------------------------------------------------------
  // single-cycle pulses; the address bus shows junk outside them
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rpt    <= '0;
      last_r <= 32'h0;
    end
    else if (go)
    begin
      rpt    <= want;
      last_r <= want.addr;
    end
    else
    begin
      rpt <= fel_report_t'({18'h0, ~last_r});
    end
  end
endmodule

`default_nettype wire

// ==== verif/fault_escalation_lockup_test.sv ====
// self-checking bench for the fault escalation and lockup unit
// assumes fel_top, fel_pkg, fel_defs.svh and fel_src_model
`timescale 1ns/1ps
`default_nettype none
`include "fel_defs.svh"

module fault_escalation_lockup_test
  import fel_pkg::*;
;
  logic               mclk;
  logic               rst;
  logic [`FEL_AW-1:0] paddr;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  fel_report_t        rpt;
  fel_report_t        want;
  fel_ctx_t           ctx;
  logic               nmi_req;
  logic               dbg_halt;
  fel_req_t           fault_req;
  logic               lockup;
  logic               go;
  logic [31:0]        a;
  logic [32:0]        e;
  logic [7:0]         off;
  logic               cap;
  int                 bad_count = 0;
  int                 checked = 0;
  int                 cycles = 0;
  logic [32:0]        apb_q[$];
  logic [3:0]         req_q[$];
  // request class {hard,memm,busf,usage} and status bit of each cause
  int cls_t [18] = '{8, 4, 4, 4, 4, 4, 2, 2, 2, 2, 2, 1, 1, 1, 1, 1, 1, 1};
  int bit_t [18] = '{1, 0, 0, 1, 4, 3, 4, 3, 0, 1, 2, 3, 0, 1, 1, 2, 8, 9};

  fel_top u_dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rpt(rpt), .ctx(ctx),
    .nmi_req(nmi_req), .dbg_halt(dbg_halt), .fault_req(fault_req),
    .lockup(lockup));

  fel_src_model u_src (.mclk(mclk), .rst(rst), .go(go), .want(want),
    .rpt(rpt));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------------
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp,
                     input string what);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      $display("ERROR %0t run timed out", $time);
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [`FEL_AW-1:0] ad,
                     input logic [31:0] wd, input logic [32:0] exp);
    @(posedge mclk);
    apb_q.push_back(exp);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [`FEL_AW-1:0] ad, input logic [31:0] d);
    apb(1'b0, ad, 32'h0, {1'b0, d});
  endtask

  task automatic wr(input logic [`FEL_AW-1:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 33'h0);
  endtask

  task automatic fire(input int i, input fel_exc_t act, input logic [2:0] pr,
                      input logic bfs, input logic [3:0] exp);
    fel_report_t w;
    @(posedge mclk);
    a = $urandom;
    w = '0;
    w[i == 10 ? 40 : 49 - i] = 1'b1;
    w.data_err_exact = (i == 9);
    w.addr = a;
    want <= w;
    ctx <= '{act, pr, bfs};
    go  <= 1'b1;
    if (exp != 4'h0)
      req_q.push_back(exp);
    @(posedge mclk);
    go <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic pulse_in(input logic which);
    @(posedge mclk);
    if (which)
      nmi_req <= 1'b1;
    else
      dbg_halt <= 1'b1;
    @(posedge mclk);
    nmi_req  <= 1'b0;
    dbg_halt <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------------
  // watcher: takes the oldest note whenever a result appears
  // ----------------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!rst && fault_req !== 4'h0)
    begin
      if (req_q.size() == 0)
        cmp({29'h0, fault_req}, 33'h0, "unexpected request");
      else
        cmp({29'h0, fault_req}, {29'h0, req_q.pop_front()}, "request");
    end
    if (psel && penable && pready)
    begin
      e = apb_q.pop_front();
      if (pwrite)
        cmp({pslverr, 32'h0}, {e[32], 32'h0}, "write response");
      else
        cmp({pslverr, prdata}, e, "read data");
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    want = '0;
    ctx = '0;
    go = 1'b0;
    nmi_req = 1'b0;
    dbg_halt = 1'b0;
    void'($urandom(32'h77b1ccd3));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 9; k++) rd(8'(k * 4), 32'h0);
    apb(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h24, 32'h5, {1'b1, 32'h0});
    wr(`FEL_OFF_PRI, 32'hffff_ffff);
    rd(`FEL_OFF_PRI, 32'h0007_0707);
    wr(`FEL_OFF_PRI, 32'h0002_0100);
    wr(`FEL_OFF_HCTL, 32'h7);
    for (int i = 0; i < 18; i++)
    begin
      fire(i, FEL_EXC_THREAD, 3'h0, 1'b0, cls_t[i][3:0]);
      off = cls_t[i] == 8 ? 8'h00 : cls_t[i] == 4 ? 8'h04 :
            cls_t[i] == 2 ? 8'h08 : 8'h0c;
      cap = (i inside {1, 2, 3, 8, 9});
      rd(off, (32'h1 << bit_t[i]) | (cap ? 32'h80 : 32'h0));
      if (cap) rd(off == 8'h04 ? 8'h10 : 8'h14, a);
      wr(off, 32'hffff_ffff);
      rd(off, 32'h0);
    end
    fire(17, FEL_EXC_OTHER, 3'h2, 1'b0, 4'h8);
    fire(17, FEL_EXC_OTHER, 3'h3, 1'b0, 4'h1);
    fire(17, FEL_EXC_USAGE, 3'h0, 1'b0, 4'h8);
    fire(3, FEL_EXC_BUSF, 3'h0, 1'b0, 4'h4);
    fire(12, FEL_EXC_BUSF, 3'h0, 1'b0, 4'h8);
    fire(6, FEL_EXC_BUSF, 3'h0, 1'b1, 4'h2);
    fire(0, FEL_EXC_OTHER, 3'h0, 1'b0, 4'h8);
    rd(`FEL_OFF_HFS, 32'h4000_0002);
    wr(`FEL_OFF_HCTL, 32'h0);
    for (int k = 0; k < 4; k++) wr(8'(k * 4), 32'hffff_ffff);
    fire(2, FEL_EXC_THREAD, 3'h0, 1'b0, 4'h8);
    fire(17, FEL_EXC_THREAD, 3'h0, 1'b0, 4'h8);
    rd(`FEL_OFF_HFS, 32'h4000_0000);
    fire(17, FEL_EXC_HARD, 3'h0, 1'b0, 4'h0);
    cmp({32'h0, lockup}, 33'h1, "lockup from hard");
    rd(`FEL_OFF_LOCK, 32'h1);
    fire(17, FEL_EXC_THREAD, 3'h0, 1'b0, 4'h0);
    pulse_in(1'b1);
    cmp({32'h0, lockup}, 33'h0, "nmi exit");
    fire(0, FEL_EXC_NMI, 3'h0, 1'b0, 4'h0);
    rd(`FEL_OFF_LOCK, 32'h2);
    pulse_in(1'b1);
    cmp({32'h0, lockup}, 33'h1, "nmi ignored");
    pulse_in(1'b0);
    cmp({32'h0, lockup}, 33'h0, "halt exit");
    fire(0, FEL_EXC_HARD, 3'h0, 1'b0, 4'h0);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmp({32'h0, lockup}, 33'h0, "reset exit");
    rd(`FEL_OFF_LOCK, 32'h0);
    repeat (3) @(posedge mclk);
    cmp(33'(apb_q.size() + req_q.size()), 33'h0, "notes left");
    close_out();
  end
endmodule

`default_nettype wire
